/* hw/rmjs_fifo.v */
`timescale 1ns/1ps
module rmjs_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    // Handshakes and honest full and empty
    assign o_in_ready = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != {(AW+1){1'b0}});
    assign o_out_data = mem[rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Storage write
    always @(posedge i_clk_sys)
    begin
        if (push)
            mem[wr_ptr] <= i_in_data;
    end

    // Pointers and fill count
    always @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

/* hw/rmjs_map.vh */
`ifndef RMJS_MAP_VH
`define RMJS_MAP_VH
// Frame layout
`define RMJS_HDR_LEN 5'd16
`define RMJS_SYS_ID0 8'h53
`define RMJS_SYS_ID1 8'h35
`define RMJS_HDR_LEN_BYTE 8'h10
`define RMJS_OPID 8'h01
`define RMJS_OPLEN 8'h03
`define RMJS_OP_WR_REQ 8'h03
`define RMJS_OP_WR_ACK 8'h04
`define RMJS_OP_RD_REQ 8'h05
`define RMJS_OP_RD_RSP 8'h06
`define RMJS_AREA_FIELD 8'h03
`define RMJS_AREA_FLEN 8'h08
`define RMJS_ACK_FIELD 8'h0F
`define RMJS_ACK_FLEN 8'h03
`define RMJS_EMPTY 8'hFF
`define RMJS_REQ_EMPTY_LEN 8'h02
`define RMJS_ACK_EMPTY_LEN 8'h07
`define RMJS_FREE 8'h00
// Area codes
`define RMJS_AREA_DATA_BLOCK 8'h01
`define RMJS_AREA_BIT_MEM 8'h02
`define RMJS_AREA_INPUT_IMAGE 8'h03
`define RMJS_AREA_OUTPUT_IMAGE 8'h04
`define RMJS_AREA_DIRECT_IO 8'h05
`define RMJS_AREA_COUNTERS 8'h06
`define RMJS_AREA_TIMERS 8'h07
// Error numbers
`define RMJS_ERR_NONE 8'h00
`define RMJS_ERR_HEADER 8'h01
`define RMJS_ERR_AREA 8'h02
`define RMJS_ERR_RANGE 8'h03
`define RMJS_ERR_BLOCK 8'h04
// Header byte indices
`define RMJS_B_OPCODE 5'd5
`define RMJS_B_AREA 5'd8
`define RMJS_B_BLOCK 5'd9
`define RMJS_B_ADDR_HI 5'd10
`define RMJS_B_ADDR_LO 5'd11
`define RMJS_B_LEN_HI 5'd12
`define RMJS_B_LEN_LO 5'd13
`endif

/* hw/rmjs_server.v */
// Operation
// RQ1: Read and write jobs arrive as a byte stream from any transport connection and reach memory.
// RQ2: Every frame opens with a 16-byte header whose first bytes are the characters S and 5.
// RQ3: Header bytes 2, 3 and 4 carry header length 16, opcode identifier 01 and opcode length 03.
// RQ4: A write request carries opcode 03, area field 03/08, area, block, address, length, FF/02.
// RQ5: A read request uses the same layout with opcode 05 and carries no data.
// RQ6: A write is answered with opcode 04, ack field 0F/03, error number, empty field FF/07.
// RQ7: A read is answered with opcode 06 and otherwise the write acknowledgement layout.
// RQ8: Write data follows the write header directly, up to 64 K bytes.
// RQ9: Read data follows the response header only when the error number is zero.
// RQ10: Area codes 01 to 07 select data block to timers; block number counts only for data blocks.
// RQ11: Unknown area or out-of-range address or length gives a non-zero error and no memory access.
`timescale 1ns/1ps
`include "rmjs_map.vh"
module rmjs_server #(
    parameter MAX_ADDR = 16'hFFFF,
    parameter MAX_LEN = 16'hFFFF
) (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire i_rx_valid,
    output reg o_rx_ready,
    input wire [7:0] i_rx_data,
    input wire i_rx_last,
    output reg o_tx_valid,
    input wire i_tx_ready,
    output reg [7:0] o_tx_data,
    output reg o_tx_last,
    output reg o_mem_wr,
    output reg o_mem_rd,
    output reg [2:0] o_mem_area,
    output reg [7:0] o_block_number,
    output reg [15:0] o_mem_addr,
    output reg [7:0] o_mem_wdata,
    input wire i_mem_rvalid,
    input wire [7:0] i_mem_rdata
);
    localparam S_HDR = 6'b000001;
    localparam S_WDATA = 6'b000010;
    localparam S_DRAIN = 6'b000100;
    localparam S_ACK = 6'b001000;
    localparam S_RDATA = 6'b010000;
    localparam S_WAIT = 6'b100000;

    reg [5:0] state;
    reg [4:0] idx;
    reg [7:0] hdr_err;
    reg is_read;
    reg [7:0] area;
    reg [15:0] addr;
    reg [15:0] len;
    reg [15:0] left;
    reg [4:0] tx_idx;
    reg rd_pending;
    reg [7:0] err_num;

    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    reg fifo_in_valid;

    // Expected request byte at each header position
    function [7:0] rmjs_req_byte;
        input [4:0] i;
        input rd;
        begin
            case (i)
                5'd0: rmjs_req_byte = `RMJS_SYS_ID0;
                5'd1: rmjs_req_byte = `RMJS_SYS_ID1;
                5'd2: rmjs_req_byte = `RMJS_HDR_LEN_BYTE;
                5'd3: rmjs_req_byte = `RMJS_OPID;
                5'd4: rmjs_req_byte = `RMJS_OPLEN;
                5'd5: rmjs_req_byte = rd ? `RMJS_OP_RD_REQ : `RMJS_OP_WR_REQ;
                5'd6: rmjs_req_byte = `RMJS_AREA_FIELD;
                5'd7: rmjs_req_byte = `RMJS_AREA_FLEN;
                5'd14: rmjs_req_byte = `RMJS_EMPTY;
                5'd15: rmjs_req_byte = `RMJS_REQ_EMPTY_LEN;
                default: rmjs_req_byte = `RMJS_FREE;
            endcase
        end
    endfunction

    // Answer header byte at each position
    function [7:0] rmjs_ack_byte;
        input [4:0] i;
        input rd;
        input [7:0] err;
        begin
            case (i)
                5'd0: rmjs_ack_byte = `RMJS_SYS_ID0;
                5'd1: rmjs_ack_byte = `RMJS_SYS_ID1;
                5'd2: rmjs_ack_byte = `RMJS_HDR_LEN_BYTE;
                5'd3: rmjs_ack_byte = `RMJS_OPID;
                5'd4: rmjs_ack_byte = `RMJS_OPLEN;
                5'd5: rmjs_ack_byte = rd ? `RMJS_OP_RD_RSP : `RMJS_OP_WR_ACK;
                5'd6: rmjs_ack_byte = `RMJS_ACK_FIELD;
                5'd7: rmjs_ack_byte = `RMJS_ACK_FLEN;
                5'd8: rmjs_ack_byte = err;
                5'd9: rmjs_ack_byte = `RMJS_EMPTY;
                5'd10: rmjs_ack_byte = `RMJS_ACK_EMPTY_LEN;
                default: rmjs_ack_byte = `RMJS_FREE;
            endcase
        end
    endfunction

    // Byte count of a job: data blocks, counters and timers count in words
    function [16:0] rmjs_bytes;
        input [7:0] a;
        input [15:0] l;
        begin
            if (a == `RMJS_AREA_DATA_BLOCK || a == `RMJS_AREA_COUNTERS ||
                a == `RMJS_AREA_TIMERS)
                rmjs_bytes = {l, 1'b0};
            else
                rmjs_bytes = {1'b0, l};
        end
    endfunction

    wire rx_take = i_rx_valid && o_rx_ready;
    wire hdr_bad = (idx == `RMJS_B_OPCODE) ?
        (i_rx_data != `RMJS_OP_WR_REQ && i_rx_data != `RMJS_OP_RD_REQ) :
        (rmjs_req_byte(idx, is_read) != i_rx_data &&
         (idx < `RMJS_B_AREA || idx > `RMJS_B_LEN_LO)); // RQ2 RQ3 RQ4 RQ5
    wire area_ok = (area >= `RMJS_AREA_DATA_BLOCK) && (area <= `RMJS_AREA_TIMERS); // RQ10
    wire [16:0] nbytes = rmjs_bytes(area, len);
    wire range_ok = ({1'b0, addr} <= {1'b0, MAX_ADDR}) && (len != 16'h0000) &&
        (nbytes <= {1'b0, MAX_LEN}); // RQ11
    wire [7:0] final_err = (hdr_err != `RMJS_ERR_NONE || hdr_bad) ? `RMJS_ERR_HEADER :
        (!area_ok ? `RMJS_ERR_AREA : (!range_ok ? `RMJS_ERR_RANGE : `RMJS_ERR_NONE));

    // Write data passes through the FIFO into memory
    rmjs_fifo #(
        .WIDTH(8),
        .DEPTH(8),
        .AW(3)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_rx_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(1'b1),
        .o_out_data(fifo_out_data)
    );

    // Stream write bytes into the FIFO while the job is good
    always @*
    begin
        fifo_in_valid = (state == S_WDATA) && rx_take && fifo_in_ready; // RQ8
    end

    // Request parser, memory sequencer and answer generator
    always @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state <= S_HDR;
            idx <= 5'h00;
            hdr_err <= `RMJS_ERR_NONE;
            is_read <= 1'b0;
            area <= 8'h00;
            addr <= 16'h0000;
            len <= 16'h0000;
            left <= 16'h0000;
            tx_idx <= 5'h00;
            rd_pending <= 1'b0;
            err_num <= `RMJS_ERR_NONE;
            o_rx_ready <= 1'b0;
            o_tx_valid <= 1'b0;
            o_tx_data <= 8'h00;
            o_tx_last <= 1'b0;
            o_mem_wr <= 1'b0;
            o_mem_rd <= 1'b0;
            o_mem_area <= 3'h0;
            o_block_number <= 8'h00;
            o_mem_addr <= 16'h0000;
            o_mem_wdata <= 8'h00;
        end
        else
        begin
            o_mem_wr <= 1'b0;
            o_mem_rd <= 1'b0;
            // FIFO drain: one memory write per byte
            if (fifo_out_valid)
            begin
                o_mem_wr <= 1'b1; // RQ1
                o_mem_wdata <= fifo_out_data;
            end
            // Each write pulse steps the address, so gaps in the data keep the count
            if (o_mem_wr)
                o_mem_addr <= o_mem_addr + 16'h0001;
            if (o_tx_valid && i_tx_ready)
                o_tx_valid <= 1'b0;
            case (state)
                S_HDR:
                begin
                    o_rx_ready <= !o_tx_valid || i_tx_ready; // Not while an answer byte waits
                    if (rx_take)
                    begin
                        idx <= idx + 5'h01;
                        if (idx == `RMJS_B_OPCODE)
                            is_read <= (i_rx_data == `RMJS_OP_RD_REQ);
                        if (hdr_bad && hdr_err == `RMJS_ERR_NONE)
                            hdr_err <= `RMJS_ERR_HEADER;
                        if (idx == `RMJS_B_AREA)
                            area <= i_rx_data;
                        if (idx == `RMJS_B_BLOCK)
                            o_block_number <= i_rx_data; // RQ10
                        if (idx == `RMJS_B_ADDR_HI)
                            addr[15:8] <= i_rx_data;
                        if (idx == `RMJS_B_ADDR_LO)
                            addr[7:0] <= i_rx_data;
                        if (idx == `RMJS_B_LEN_HI)
                            len[15:8] <= i_rx_data;
                        if (idx == `RMJS_B_LEN_LO)
                            len[7:0] <= i_rx_data;
                        if (idx == `RMJS_HDR_LEN - 5'd1)
                        begin
                            idx <= 5'h00;
                            err_num <= final_err;
                            left <= nbytes[15:0];
                            o_mem_area <= area[2:0];
                            o_mem_addr <= addr;
                            if (!is_read && !i_rx_last)
                                state <= (final_err == `RMJS_ERR_NONE) ? S_WDATA : S_DRAIN;
                            else
                            begin
                                o_rx_ready <= 1'b0;
                                state <= S_ACK;
                            end
                        end
                    end
                end
                S_WDATA:
                begin
                    o_rx_ready <= !(fifo_in_valid && i_rx_last);
                    if (fifo_in_valid && i_rx_last)
                        state <= S_WAIT;
                end
                S_DRAIN:
                begin
                    o_rx_ready <= 1'b1; // RQ11
                    if (rx_take && i_rx_last)
                    begin
                        o_rx_ready <= 1'b0;
                        state <= S_ACK;
                    end
                end
                S_WAIT:
                begin
                    if (!fifo_out_valid && !o_mem_wr)
                        state <= S_ACK;
                end
                S_ACK:
                begin
                    if (!o_tx_valid || i_tx_ready)
                    begin
                        o_tx_valid <= 1'b1;
                        o_tx_data <= rmjs_ack_byte(tx_idx, is_read, err_num); // RQ6 RQ7
                        tx_idx <= tx_idx + 5'h01;
                        o_tx_last <= (tx_idx == `RMJS_HDR_LEN - 5'd1) &&
                            !(is_read && err_num == `RMJS_ERR_NONE); // RQ9
                        if (tx_idx == `RMJS_HDR_LEN - 5'd1)
                        begin
                            tx_idx <= 5'h00;
                            state <= (is_read && err_num == `RMJS_ERR_NONE) ? S_RDATA : S_HDR;
                            hdr_err <= `RMJS_ERR_NONE;
                        end
                    end
                end
                S_RDATA:
                begin
                    if (!rd_pending && (!o_tx_valid || i_tx_ready))
                    begin
                        o_mem_rd <= 1'b1; // RQ9
                        rd_pending <= 1'b1;
                    end
                    if (rd_pending && i_mem_rvalid)
                    begin
                        rd_pending <= 1'b0;
                        o_tx_valid <= 1'b1;
                        o_tx_data <= i_mem_rdata;
                        o_tx_last <= (left == 16'h0001);
                        o_mem_addr <= o_mem_addr + 16'h0001;
                        left <= left - 16'h0001;
                        if (left == 16'h0001)
                            state <= S_HDR;
                    end
                end
                default:
                    state <= S_HDR;
            endcase
        end
    end
endmodule

/* testbench/rmjs_server_props.sv */
`timescale 1ns/1ps
module rmjs_server_props (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire o_rx_ready,
    input wire o_tx_valid,
    input wire i_tx_ready,
    input wire [7:0] o_tx_data,
    input wire o_tx_last,
    input wire o_mem_wr,
    input wire o_mem_rd,
    input wire [2:0] o_mem_area
);
    logic [4:0] idx;
    logic [7:0] err;
    logic [7:0] op;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    // Byte position in the answer and the opcode and error seen in it
    always @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            idx <= 5'h00;
            err <= 8'h00;
            op <= 8'h00;
        end
        else if (o_tx_valid && i_tx_ready)
        begin
            idx <= o_tx_last ? 5'h00 : (idx == 5'h1F ? idx : idx + 5'h01);
            if (idx == 5'h05)
                op <= o_tx_data;
            if (idx == 5'h08)
                err <= o_tx_data;
        end
    end
    property p_sysid; o_tx_valid && idx < 5'h02 |-> o_tx_data == (idx == 5'h00 ? 8'h53 : 8'h35);
    endproperty
    a_sysid: assert property (p_sysid) else $error("system id wrong");
    property p_fixed; o_tx_valid && idx inside {[2:4]} |->
        o_tx_data == (idx == 5'h02 ? 8'h10 : (idx == 5'h03 ? 8'h01 : 8'h03)); endproperty
    a_fixed: assert property (p_fixed) else $error("header length or opcode id wrong");
    property p_opcode; o_tx_valid && idx == 5'h05 |-> o_tx_data inside {8'h04, 8'h06}; endproperty
    a_opcode: assert property (p_opcode) else $error("answer opcode wrong");
    property p_ackfld; o_tx_valid && idx inside {[6:7]} |->
        o_tx_data == (idx == 5'h06 ? 8'h0F : 8'h03); endproperty
    a_ackfld: assert property (p_ackfld) else $error("ack field wrong");
    property p_empty; o_tx_valid && idx inside {[9:15]} |->
        o_tx_data == (idx == 5'h09 ? 8'hFF : (idx == 5'h0A ? 8'h07 : 8'h00)); endproperty
    a_empty: assert property (p_empty) else $error("empty field wrong");
    property p_hold; o_tx_valid && !i_tx_ready |=>
        o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last); endproperty
    a_hold: assert property (p_hold) else $error("answer byte not held");
    property p_short; o_tx_valid && o_tx_last |-> idx >= 5'h0F; endproperty
    a_short: assert property (p_short) else $error("answer shorter than header");
    property p_endhdr; o_tx_valid && idx == 5'h0F && (err != 8'h00 || op == 8'h04) |->
        o_tx_last; endproperty
    a_endhdr: assert property (p_endhdr) else $error("header-only answer not ended");
    property p_area; o_mem_wr || o_mem_rd |-> o_mem_area != 3'h0; endproperty
    a_area: assert property (p_area) else $error("memory access with bad area");
    property p_busy; o_tx_valid |-> !o_rx_ready; endproperty
    a_busy: assert property (p_busy) else $error("request taken while answering");
    c_wrack: cover property (o_tx_valid && idx == 5'h05 && o_tx_data == 8'h04);
    c_rddata: cover property (o_tx_valid && idx == 5'h10);
    c_err: cover property (o_tx_valid && idx == 5'h09 && err != 8'h00);
    c_wr: cover property (o_mem_wr);
endmodule
bind rmjs_server rmjs_server_props rmjs_server_props_inst (.i_clk_sys, .i_nrst, .o_rx_ready,
    .o_tx_valid, .i_tx_ready, .o_tx_data, .o_tx_last, .o_mem_wr, .o_mem_rd, .o_mem_area);

/* testbench/rmjs_station.sv */
`timescale 1ns/1ps
module rmjs_station (
    input wire i_clk_sys,
    input wire i_ready,
    output logic o_valid,
    output logic [7:0] o_data,
    output logic o_last,
    input wire i_valid,
    input wire [7:0] i_data,
    input wire i_last,
    output logic o_ready
);
    logic [7:0] ans[$];
    int last_at = 0;
    logic [2:0] cyc = 3'h0;
    initial
    begin
        o_valid = 0;
        o_data = 8'h00;
        o_last = 0;
        o_ready = 0;
    end
    // Answer sink, stalling two cycles in eight
    always @(posedge i_clk_sys)
    begin
        if (i_valid && o_ready)
        begin
            ans.push_back(i_data);
            if (i_last)
                last_at = ans.size();
        end
        cyc <= cyc + 3'h1;
        #1 o_ready = (cyc[2:1] != 2'b11);
    end
    // Sends a frame back to back, each byte held until taken
    task automatic send(input logic [7:0] f[$]);
        for (int k = 0; k < f.size(); k++)
        begin
            o_valid = 1;
            o_data = f[k];
            o_last = (k == f.size() - 1);
            @(posedge i_clk_sys);
            while (!i_ready)
                @(posedge i_clk_sys);
            #1;
        end
        o_valid = 0;
        o_data = ~o_data;
        o_last = 0;
    endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic i_clk_sys = 0;
    logic i_nrst = 0;
    logic i_mem_rvalid = 0;
    logic [7:0] i_mem_rdata = 8'h00;
    wire i_rx_valid, i_rx_last, o_rx_ready, o_tx_valid, o_tx_last, i_tx_ready, o_mem_wr, o_mem_rd;
    wire [7:0] i_rx_data, o_tx_data, o_block_number, o_mem_wdata;
    wire [2:0] o_mem_area;
    wire [15:0] o_mem_addr;
    int fail_count = 0, n_checks = 0, cycles = 0, wcnt = 0, rcnt = 0, dly = 0, ra = 0;
    int seed = 32'h9ea8fa4e;
    logic [7:0] mem[int];
    logic [7:0] sh[int];
    logic [7:0] f[$];
    logic [7:0] ex[$];
    rmjs_server rmjs_server_inst (.i_clk_sys, .i_nrst, .i_rx_valid, .o_rx_ready, .i_rx_data,
        .i_rx_last, .o_tx_valid, .i_tx_ready, .o_tx_data, .o_tx_last, .o_mem_wr, .o_mem_rd,
        .o_mem_area, .o_block_number, .o_mem_addr, .o_mem_wdata, .i_mem_rvalid, .i_mem_rdata);
    rmjs_station rmjs_station_inst (.i_clk_sys(i_clk_sys), .i_ready(o_rx_ready),
        .o_valid(i_rx_valid), .o_data(i_rx_data), .o_last(i_rx_last), .i_valid(o_tx_valid),
        .i_data(o_tx_data), .i_last(o_tx_last), .o_ready(i_tx_ready));
    initial forever #5 i_clk_sys = ~i_clk_sys;
    // Block number only distinguishes data block locations
    function automatic int key(input logic [2:0] a, input logic [7:0] b, input logic [15:0] d);
        return {(a == 3'h1) ? b : 8'h00, a, d};
    endfunction
    // Memory stand-in: stores writes, answers reads after one or three cycles
    always @(posedge i_clk_sys)
    begin
        if (o_mem_wr)
        begin
            mem[key(o_mem_area, o_block_number, o_mem_addr)] = o_mem_wdata;
            wcnt++;
        end
        if (o_mem_rd)
        begin
            ra = key(o_mem_area, o_block_number, o_mem_addr);
            dly = o_mem_addr[0] ? 3 : 1;
            rcnt++;
        end
        #1;
        i_mem_rvalid = (dly == 1);
        i_mem_rdata = (dly == 1) ? (mem.exists(ra) ? mem[ra] : 8'h5A) : ~i_mem_rdata;
        if (dly > 0)
            dly--;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    // Runs one job and checks the answer and the memory traffic
    task automatic job(input bit wr, input logic [7:0] a, b, input logic [15:0] ad, ln,
        input logic [7:0] err, input bit bad);
        int n, k, w0, r0, kk;
        logic [7:0] d;
        n = (a == 8'h01 || a == 8'h06 || a == 8'h07) ? 2 * ln : ln;
        f = '{8'h53, 8'h35, 8'h10, 8'h01, 8'h03, wr ? 8'h03 : 8'h05, 8'h03, 8'h08, a, b,
            ad[15:8], ad[7:0], ln[15:8], ln[7:0], 8'hFF, 8'h02};
        if (bad)
            f[0] = 8'h54;
        ex = '{8'h53, 8'h35, 8'h10, 8'h01, 8'h03, wr ? 8'h04 : 8'h06, 8'h0F, 8'h03, err,
            8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (k = 0; k < n; k++)
        begin
            d = 8'($random(seed));
            kk = key(a[2:0], b, 16'(ad + k));
            if (wr)
                f.push_back(d);
            if (wr && err == 8'h00)
                sh[kk] = d;
            if (!wr && err == 8'h00)
                ex.push_back(sh.exists(kk) ? sh[kk] : 8'h5A);
        end
        if (err != 8'h00)
            n = 0;
        w0 = wcnt;
        r0 = rcnt;
        rmjs_station_inst.ans.delete();
        rmjs_station_inst.last_at = 0;
        rmjs_station_inst.send(f);
        for (k = 0; k < 3000 && rmjs_station_inst.last_at == 0; k++)
            @(posedge i_clk_sys);
        #1;
        cmp(rmjs_station_inst.ans.size(), ex.size(), "answer length");
        cmp(rmjs_station_inst.last_at, ex.size(), "last flag position");
        for (k = 0; k < ex.size() && k < rmjs_station_inst.ans.size(); k++)
            cmp(rmjs_station_inst.ans[k], ex[k], "answer byte");
        cmp(wcnt - w0, wr ? n : 0, "memory writes");
        cmp(rcnt - r0, wr ? 0 : n, "memory reads");
        $display("job opcode %0h area %0h error %0h done", f[5], a, err);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Cuts a hung run short
    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            $display("[FAIL] %0t run did not finish", $time);
            final_report();
        end
    end
    // Corner cases first, then random write and read-back over every area
    initial
    begin
        logic [7:0] av, bv;
        logic [15:0] dv, lv;
        repeat (10) @(posedge i_clk_sys);
        #1 i_nrst = 1;
        repeat (2) @(posedge i_clk_sys);
        #1;
        job(1, 8'h01, 8'h05, 16'h0100, 16'h0002, 8'h00, 0);
        job(0, 8'h01, 8'h05, 16'h0100, 16'h0002, 8'h00, 0);
        job(0, 8'h00, 8'h00, 16'h0000, 16'h0001, 8'h02, 0);
        job(1, 8'h08, 8'h00, 16'h0000, 16'h0001, 8'h02, 0);
        job(0, 8'h02, 8'h00, 16'h0000, 16'h0001, 8'h01, 1);
        job(0, 8'h03, 8'h00, 16'h0010, 16'h0000, 8'h03, 0);
        for (int i = 0; i < 14; i++)
        begin
            av = 8'(1 + i % 7);
            bv = 8'($random(seed));
            dv = 16'($random(seed)) & 16'h0FFF;
            lv = 16'(1 + ($random(seed) & 3));
            job(1, av, bv, dv, lv, 8'h00, 0);
            job(0, av, bv, dv, lv, 8'h00, 0);
        end
        final_report();
    end
endmodule
